// ### shared/led_status_pkg.sv
package led_status_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned BLINK_HALF_MS = 200;
  localparam int unsigned FLASH_ON_MS = 200;
  localparam int unsigned FLASH_GAP_MS = 200;
  localparam int unsigned FLASH_LONG_OFF_MS = 1000;
  localparam int unsigned SINGLE_PERIOD_MS = FLASH_ON_MS + FLASH_LONG_OFF_MS;
  localparam int unsigned DOUBLE_PERIOD_MS = 2 * FLASH_ON_MS + FLASH_GAP_MS + FLASH_LONG_OFF_MS;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_EN_OFS = 8'h0c;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] BAUD_OFS = 8'h14;

  // CTRL fields.
  localparam int CTRL_CHAN_LSB = 0;
  localparam int CTRL_CFG_BAD_BIT = 2;
  localparam int CTRL_WARN_BIT = 3;
  localparam int CTRL_BUSOFF_BIT = 4;
  localparam int CTRL_RESTART_BIT = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  // Interrupt bits: error indicator class change, channel state change, restart done.
  localparam int IRQ_ERR_BIT = 0;
  localparam int IRQ_RUN_BIT = 1;
  localparam int IRQ_BOOT_BIT = 2;
  localparam int IRQ_W = 3;

  // Baud rate code 0..8: 2.4k,9.6k,19.2k,38.4k,57.6k,115.2k,230.4k,460.8k,1M.
  localparam logic [3:0] BAUD_RESET = 4'h4;
  localparam logic [3:0] BAUD_MAX = 4'h8;

  // ----------------------------------------------------------------
  // Channel states and patterns
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    CHAN_PREOP = 2'h0,
    CHAN_STOPPED = 2'h1,
    CHAN_OPEN = 2'h2
  } chan_t;

  typedef enum logic [4:0]
  {
    PAT_OFF = 5'h01,
    PAT_ON = 5'h02,
    PAT_BLINK = 5'h04,
    PAT_SINGLE = 5'h08,
    PAT_DOUBLE = 5'h10
  } pat_t;

  typedef enum logic [2:0]
  {
    BOOT_IDLE = 3'h1,
    BOOT_ON = 3'h2,
    BOOT_OFF = 3'h4
  } boot_t;

endpackage

// ### core/led_status.sv
module led_status #(
  parameter int unsigned TICK_CYCLES = led_status_pkg::TICK_CYCLES
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interface select strap and serial path control
  input wire logic ttl_sel,
  output logic shifter_en,
  output logic ttl_path,
  // Indicators
  output logic run_led_n,
  output logic err_led_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // Strap synchroniser
  // ----------------------------------------------------------------
  // An undriven strap is modelled as low by the pad pull-down outside this logic.
  logic sel_s1_q;
  logic sel_s2_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
    end
    else
    begin
      sel_s1_q <= ttl_sel;
      sel_s2_q <= sel_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      shifter_en <= 1'b1;
      ttl_path <= 1'b0;
    end
    else
    begin
      shifter_en <= !sel_s2_q;
      ttl_path <= sel_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  localparam int IRQ_W_L = led_status_pkg::IRQ_W;
  logic [5:0] ctrl_q;
  logic [3:0] baud_q;
  logic [IRQ_W_L-1:0] irq_stat_q;
  logic [IRQ_W_L-1:0] irq_en_q;
  logic wr_acc;
  logic rd_acc;
  logic restart_pulse;
  logic [IRQ_W_L-1:0] ev;
  logic [IRQ_W_L-1:0] clr;

  // Writes land once, in the first access cycle, so a restart is not applied twice.
  assign wr_acc = psel && penable && pwrite && !pready;
  assign rd_acc = psel && penable && !pwrite;
  assign restart_pulse = wr_acc && paddr == led_status_pkg::CTRL_OFS
    && pwdata[led_status_pkg::CTRL_RESTART_BIT];
  assign clr = (wr_acc && paddr == led_status_pkg::IRQ_CLR_OFS) ? pwdata[IRQ_W_L-1:0] : '0;

  function automatic logic known_ofs(input logic [7:0] a);
    return a == led_status_pkg::CTRL_OFS || a == led_status_pkg::STATUS_OFS
      || a == led_status_pkg::IRQ_STAT_OFS || a == led_status_pkg::IRQ_EN_OFS
      || a == led_status_pkg::IRQ_CLR_OFS || a == led_status_pkg::BAUD_OFS;
  endfunction

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= led_status_pkg::CTRL_RESET;
      baud_q <= led_status_pkg::BAUD_RESET;
      irq_en_q <= '0;
    end
    else if (wr_acc)
    begin
      if (paddr == led_status_pkg::CTRL_OFS)
      begin
        ctrl_q <= {1'b0, pwdata[4:0]};
      end
      if (paddr == led_status_pkg::IRQ_EN_OFS)
      begin
        irq_en_q <= pwdata[IRQ_W_L-1:0];
      end
      // Codes beyond the nine supported rates are ignored.
      if (paddr == led_status_pkg::BAUD_OFS && pwdata[3:0] <= led_status_pkg::BAUD_MAX)
      begin
        baud_q <= pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Millisecond timebase
  // ----------------------------------------------------------------
  logic [31:0] pre_q;
  logic tick;
  logic [10:0] ms_q;
  logic [7:0] blink_ms_q;
  logic blink_ph_q;

  assign tick = pre_q == TICK_CYCLES - 1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pre_q <= '0;
    end
    else
    begin
      // A restart realigns the tick so every restart blink lasts a full half period.
      pre_q <= (tick || restart_pulse) ? '0 : pre_q + 32'h1;
    end
  end

  // Blink phase: 200 ms halves give 2.5 Hz.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blink_ms_q <= '0;
      blink_ph_q <= 1'b1;
    end
    else if (tick)
    begin
      if (blink_ms_q == 8'(led_status_pkg::BLINK_HALF_MS - 1))
      begin
        blink_ms_q <= '0;
        blink_ph_q <= !blink_ph_q;
      end
      else
      begin
        blink_ms_q <= blink_ms_q + 8'h1;
      end
    end
  end

  // Two ms counters: ms_q spans the 1600 ms double-flash frame, sgl_ms_q the 1200 ms single-flash frame.
  logic [10:0] sgl_ms_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ms_q <= '0;
      sgl_ms_q <= '0;
    end
    else if (tick)
    begin
      ms_q <= (ms_q == 11'(led_status_pkg::DOUBLE_PERIOD_MS - 1)) ? '0 : ms_q + 11'h1;
      sgl_ms_q <= (sgl_ms_q == 11'(led_status_pkg::SINGLE_PERIOD_MS - 1)) ? '0
        : sgl_ms_q + 11'h1;
    end
  end

  function automatic logic pat_lit(input led_status_pkg::pat_t p, input logic bph,
    input logic [10:0] sm, input logic [10:0] dm);
    logic r;
    r = 1'b0;
    unique case (p)
      led_status_pkg::PAT_OFF: r = 1'b0;
      led_status_pkg::PAT_ON: r = 1'b1;
      led_status_pkg::PAT_BLINK: r = bph;
      led_status_pkg::PAT_SINGLE: r = sm < 11'(led_status_pkg::FLASH_ON_MS);
      led_status_pkg::PAT_DOUBLE: r = dm < 11'(led_status_pkg::FLASH_ON_MS)
        || (dm >= 11'(led_status_pkg::FLASH_ON_MS + led_status_pkg::FLASH_GAP_MS)
        && dm < 11'(2 * led_status_pkg::FLASH_ON_MS + led_status_pkg::FLASH_GAP_MS));
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Restart blink sequence
  // ----------------------------------------------------------------
  // Blink count is baud code plus one, so every rate gives at least one blink.
  led_status_pkg::boot_t boot_q;
  logic [3:0] boot_left_q;
  logic [7:0] boot_ms_q;
  logic boot_step;

  assign boot_step = tick && boot_ms_q == 8'(led_status_pkg::BLINK_HALF_MS - 1);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      boot_q <= led_status_pkg::BOOT_ON;
      boot_left_q <= led_status_pkg::BAUD_RESET;
      boot_ms_q <= '0;
    end
    else if (restart_pulse)
    begin
      boot_q <= led_status_pkg::BOOT_ON;
      boot_left_q <= baud_q;
      boot_ms_q <= '0;
    end
    else
    begin
      if (tick)
      begin
        boot_ms_q <= boot_step ? '0 : boot_ms_q + 8'h1;
      end
      unique case (boot_q)
        led_status_pkg::BOOT_IDLE: boot_q <= led_status_pkg::BOOT_IDLE;
        led_status_pkg::BOOT_ON:
        begin
          if (boot_step)
          begin
            boot_q <= led_status_pkg::BOOT_OFF;
          end
        end
        led_status_pkg::BOOT_OFF:
        begin
          if (boot_step)
          begin
            if (boot_left_q == 4'h0)
            begin
              boot_q <= led_status_pkg::BOOT_IDLE;
            end
            else
            begin
              boot_q <= led_status_pkg::BOOT_ON;
              boot_left_q <= boot_left_q - 4'h1;
            end
          end
        end
        default: boot_q <= led_status_pkg::BOOT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pattern selection and outputs
  // ----------------------------------------------------------------
  led_status_pkg::pat_t run_pat;
  led_status_pkg::pat_t err_pat;
  logic [1:0] err_class;
  logic [1:0] err_class_q;
  logic [1:0] chan_q;

  always_comb
  begin
    unique case (ctrl_q[1:0])
      led_status_pkg::CHAN_STOPPED: run_pat = led_status_pkg::PAT_SINGLE;
      led_status_pkg::CHAN_OPEN: run_pat = led_status_pkg::PAT_ON;
      default: run_pat = led_status_pkg::PAT_BLINK;
    endcase
  end

  always_comb
  begin
    if (ctrl_q[led_status_pkg::CTRL_BUSOFF_BIT])
    begin
      err_pat = led_status_pkg::PAT_ON;
      err_class = 2'h3;
    end
    else if (ctrl_q[led_status_pkg::CTRL_WARN_BIT])
    begin
      err_pat = led_status_pkg::PAT_SINGLE;
      err_class = 2'h2;
    end
    else if (ctrl_q[led_status_pkg::CTRL_CFG_BAD_BIT])
    begin
      err_pat = led_status_pkg::PAT_BLINK;
      err_class = 2'h1;
    end
    else
    begin
      err_pat = led_status_pkg::PAT_OFF;
      err_class = 2'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_led_n <= 1'b1;
      err_led_n <= 1'b1;
    end
    else
    begin
      run_led_n <= !pat_lit(run_pat, blink_ph_q, sgl_ms_q, ms_q);
      if (boot_q != led_status_pkg::BOOT_IDLE)
      begin
        err_led_n <= !(boot_q == led_status_pkg::BOOT_ON);
      end
      else
      begin
        err_led_n <= !pat_lit(err_pat, blink_ph_q, sgl_ms_q, ms_q);
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  logic boot_done;
  assign boot_done = boot_q == led_status_pkg::BOOT_OFF && boot_step && boot_left_q == 4'h0
    && !restart_pulse;
  assign ev = {boot_done, chan_q != ctrl_q[1:0], err_class_q != err_class};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      err_class_q <= '0;
      chan_q <= '0;
      irq_stat_q <= '0;
      irq <= 1'b0;
    end
    else
    begin
      err_class_q <= err_class;
      chan_q <= ctrl_q[1:0];
      // A new event wins over a clear written in the same cycle.
      irq_stat_q <= (irq_stat_q & ~clr) | ev;
      irq <= |(((irq_stat_q & ~clr) | ev) & irq_en_q);
    end
  end

  // ----------------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      // One wait state: pready rises in the second access cycle.
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !known_ofs(paddr);
      prdata <= '0;
      if (rd_acc && !pready)
      begin
        unique case (paddr)
          led_status_pkg::CTRL_OFS: prdata <= {26'h0, ctrl_q};
          led_status_pkg::STATUS_OFS: prdata <= {24'h0, boot_q != led_status_pkg::BOOT_IDLE,
            sel_s2_q, err_class, !err_led_n, !run_led_n, ctrl_q[1:0]};
          led_status_pkg::IRQ_STAT_OFS: prdata <= {29'h0, irq_stat_q};
          led_status_pkg::IRQ_EN_OFS: prdata <= {29'h0, irq_en_q};
          led_status_pkg::BAUD_OFS: prdata <= {28'h0, baud_q};
          default: prdata <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_busoff_lit: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q[4] && boot_q == led_status_pkg::BOOT_IDLE) |=> !err_led_n)
    else $error("bus off but error indicator dark");
  a_open_lit: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q[1:0] == 2'h2) |=> !run_led_n)
    else $error("channel open but run indicator dark");
  a_sel_path: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(sel_s2_q) |=> (!shifter_en && ttl_path))
    else $error("strap high did not disable shifter");
  a_no_err_dark: assert property (@(posedge pclk) disable iff (!presetn)
    (ctrl_q[4:2] == 3'h0 && boot_q == led_status_pkg::BOOT_IDLE) |=> err_led_n)
    else $error("no error but error indicator lit");
  a_strap_low: assert property (@(posedge pclk) disable iff (!presetn)
    !sel_s2_q |=> (shifter_en && !ttl_path))
    else $error("strap low but shifter path not selected");
  a_boot_dark: assert property (@(posedge pclk) disable iff (!presetn)
    (boot_q == led_status_pkg::BOOT_OFF) |=> err_led_n)
    else $error("restart blink dark phase but error indicator lit");

endmodule

// ### testbench/led_host_model.sv
// ----------------------------------------------------------------
// Board side: strap pad, indicator loads and host serial pins
// ----------------------------------------------------------------
module led_host_model
(
  // Strap as driven by the board
  input wire logic strap_oe,
  input wire logic strap_val,
  output logic ttl_sel,
  // Indicator lines
  input wire logic run_led_n,
  input wire logic err_led_n,
  output logic run_lit,
  output logic err_lit,
  // Serial path
  input wire logic ttl_path,
  output logic host_pins_on
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released strap reads low because the pad is pulled down.
  assign ttl_sel = strap_oe ? strap_val : 1'b0;
  assign run_lit = ~run_led_n;
  assign err_lit = ~err_led_n;
  // The host keeps off the logic-level pins until the block hands them over.
  assign host_pins_on = ttl_path;
endmodule

// ### testbench/can_module_status_indicator_tb.sv
module can_module_status_indicator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Short tick keeps every frame of the patterns affordable.
  // ----------------------------------------------------------------
  localparam int T = 5;
  localparam int ON_T = led_status_pkg::FLASH_ON_MS * T;
  localparam int W = led_status_pkg::SINGLE_PERIOD_MS * T;
  localparam int BL = led_status_pkg::BLINK_HALF_MS * T;
  logic pclk, presetn, psel, penable, pwrite, ttl_sel, strap_oe, strap_val, acc_clr, se;
  logic pready, pslverr, shifter_en, ttl_path, run_led_n, err_led_n, irq;
  logic run_lit, err_lit, host_pins_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed, code;
  int n_mismatch, tests_run, err_acc, rl, el, k;
  logic [5:0] ctrl_tab [4] = '{6'h00, 6'h05, 6'h0e, 6'h1b};
  int run_tab [4] = '{W / 2, ON_T, W, W / 2};
  int err_tab [4] = '{0, W / 2, ON_T, W};

  led_status #(.TICK_CYCLES(T)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ttl_sel(ttl_sel), .shifter_en(shifter_en),
    .ttl_path(ttl_path), .run_led_n(run_led_n), .err_led_n(err_led_n), .irq(irq));
  led_host_model u_host (.strap_oe(strap_oe), .strap_val(strap_val), .ttl_sel(ttl_sel),
    .run_led_n(run_led_n), .err_led_n(err_led_n), .run_lit(run_lit), .err_lit(err_lit),
    .ttl_path(ttl_path), .host_pins_on(host_pins_on));

  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk)
    if (!presetn || acc_clr) err_acc <= 0;
    else if (err_lit === 1'b1) err_acc <= err_acc + 1;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task report_and_stop();
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 64);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task measure(input int n);
    rl = 0;
    el = 0;
    repeat (n)
    begin
      @(posedge pclk);
      rl += int'(run_lit === 1'b1);
      el += int'(err_lit === 1'b1);
    end
  endtask

  task wait_restart();
    k = 0;
    do
    begin
      repeat (500) @(posedge pclk);
      apb(1'b0, led_status_pkg::STATUS_OFS, 32'h0);
      k++;
    end
    while (rd[7] !== 1'b0 && k < 60);
    repeat (10) @(posedge pclk);
  endtask

  initial
  begin
    repeat (80000) @(posedge pclk);
    n_mismatch++;
    report_and_stop();
  end

  initial
  begin
    {psel, penable, pwrite, acc_clr, strap_oe, strap_val, presetn} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    seed = 32'hb77df5f6;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, led_status_pkg::BAUD_OFS, 32'h0);
    check("baud_reset", rd, 32'(led_status_pkg::BAUD_RESET));
    check("shifter_on", 32'(shifter_en), 32'h1);
    check("ttl_off", 32'(ttl_path), 32'h0);
    wait_restart();
    check("boot_lit", 32'(err_acc), 32'((led_status_pkg::BAUD_RESET + 1) * BL));
    apb(1'b0, led_status_pkg::IRQ_STAT_OFS, 32'h0);
    check("boot_irq_bit", 32'(rd[2]), 32'h1);
    check("irq_masked", 32'(irq), 32'h0);
    apb(1'b1, led_status_pkg::IRQ_CLR_OFS, 32'h7);
    apb(1'b0, led_status_pkg::IRQ_STAT_OFS, 32'h0);
    check("irq_stat_clr", rd, 32'h0);
    apb(1'b1, led_status_pkg::IRQ_EN_OFS, 32'h1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, led_status_pkg::CTRL_OFS, 32'(ctrl_tab[i]));
      repeat (4) @(posedge pclk);
      measure(W);
      check("run_lit", 32'(rl), 32'(run_tab[i]));
      check("err_lit", 32'(el), 32'(err_tab[i]));
      check("irq", 32'(irq), 32'(i > 0));
    end
    apb(1'b1, led_status_pkg::IRQ_CLR_OFS, 32'h7);
    repeat (2) @(posedge pclk);
    check("irq_cleared", 32'(irq), 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    check("unmapped_err", 32'(se), 32'h1);
    code = rnd() % 9;
    apb(1'b1, led_status_pkg::BAUD_OFS, code);
    apb(1'b1, led_status_pkg::BAUD_OFS, 32'h9 + rnd() % 7);
    apb(1'b0, led_status_pkg::BAUD_OFS, 32'h0);
    check("baud_refuse", rd, code);
    apb(1'b1, led_status_pkg::CTRL_OFS, 32'h0);
    repeat (4) @(posedge pclk);
    acc_clr <= 1'b1;
    @(posedge pclk);
    acc_clr <= 1'b0;
    apb(1'b1, led_status_pkg::CTRL_OFS, 32'h20);
    wait_restart();
    check("restart_lit", 32'(err_acc), (code + 32'h1) * 32'(BL));
    strap_oe <= 1'b1;
    strap_val <= 1'b1;
    repeat (6) @(posedge pclk);
    check("shifter_off", 32'(shifter_en), 32'h0);
    check("ttl_on", 32'(host_pins_on), 32'h1);
    strap_oe <= 1'b0;
    repeat (6) @(posedge pclk);
    check("float_shifter", 32'(shifter_en), 32'h1);
    check("float_ttl", 32'(ttl_path), 32'h0);
    report_and_stop();
  end
endmodule
